// ### hdl/dcc_top.sv
// Purpose: control and interrupt logic of one dma channel
// Assumes: event inputs are one-cycle pulses from logic on ref_clk
// Notes:   registers reached over a plain strobe port, read data one cycle late
//
// Chosen here: the register addresses and strobed register access.
module dcc_top (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        start_evt,
   input  wire logic        abort_evt,
   input  wire logic        xfer_busy,
   input  wire logic        src_beat,
   input  wire logic        dst_done_evt,
   input  wire logic        dst_half_evt,
   input  wire logic        cell_done_evt,
   input  wire logic        block_done_evt,
   input  wire logic        addr_err_evt,
   input  wire logic        lower_done,
   input  wire logic        higher_done,
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   output logic             channel_run,
   output logic             start_req,
   output logic             pattern_hit,
   output logic [1:0]       channel_priority_out,
   output logic             irq
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0]  ignore_byte_value;
   logic        ignore_byte_enable;
   logic        channel_active_flag;
   logic        pattern_length_sel;
   logic        chain_direction_sel;
   logic        channel_on;
   logic        events_while_off;
   logic        chaining_allow;
   logic        auto_enable;
   logic        event_detected;
   logic [1:0]  channel_priority;
   logic [7:0]  irq_enable;
   logic [7:0]  irq_flag;
   logic [15:0] src_size;
   logic [15:0] src_pointer;
   logic [15:0] pattern;
   logic        pattern_mode;

   // ---------------------------------------------------------------
   // decode and events
   // ---------------------------------------------------------------
   logic        wr_ctrl;
   logic        wr_irq;
   logic        wr_clr;
   logic        wr_size;
   logic        wr_pat;
   logic        evt_ok;
   logic        start_ok;
   logic        abort_ok;
   logic        chain_hit;
   logic [15:0] ptr_next;
   logic        src_done_now;
   logic        src_half_now;
   logic        block_now;
   logic [7:0]  evt_set;
   logic [31:0] ctrl_word;
   logic [31:0] irq_word;
   logic [31:0] next_rdata;

   dcc_pat_if pif ();

   // write strobes per register
   assign wr_ctrl = reg_wr && (reg_addr == dcc_pkg::OFS_CONTROL);
   assign wr_irq  = reg_wr && (reg_addr == dcc_pkg::OFS_IRQ_CTRL);
   assign wr_clr  = reg_wr && (reg_addr == dcc_pkg::OFS_IRQ_CLR);
   assign wr_size = reg_wr && (reg_addr == dcc_pkg::OFS_SRC_SIZE);
   assign wr_pat  = reg_wr && (reg_addr == dcc_pkg::OFS_PATTERN);

   // start and abort only count while on, or when allowed while off
   assign evt_ok   = channel_on || events_while_off;
   assign start_ok = start_evt && evt_ok;
   assign abort_ok = abort_evt && evt_ok;

   // completion of the chosen neighbour enables this channel
   assign chain_hit = chaining_allow && (chain_direction_sel ? lower_done : higher_done);

   // source pointer compare against full and half size
   assign ptr_next     = src_pointer + 16'h0001;
   assign src_done_now = src_beat && (ptr_next == src_size);
   assign src_half_now = src_beat && (ptr_next == (src_size >> 1));
   assign block_now    = block_done_evt || pattern_hit;

   // event vector in flag order
   always_comb begin
      evt_set = 8'h00;
      evt_set[dcc_pkg::EVT_SRC_DONE] = src_done_now;
      evt_set[dcc_pkg::EVT_SRC_HALF] = src_half_now;
      evt_set[dcc_pkg::EVT_DST_DONE] = dst_done_evt;
      evt_set[dcc_pkg::EVT_DST_HALF] = dst_half_evt;
      evt_set[dcc_pkg::EVT_BLOCK]    = block_now;
      evt_set[dcc_pkg::EVT_CELL]     = cell_done_evt;
      evt_set[dcc_pkg::EVT_ABORT]    = abort_ok;
      evt_set[dcc_pkg::EVT_ADDR_ERR] = addr_err_evt;
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // static configuration fields
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ignore_byte_value   <= dcc_pkg::RST_BYTE;
         ignore_byte_enable  <= 1'b0;
         pattern_length_sel  <= 1'b0;
         chain_direction_sel <= 1'b0;
         events_while_off    <= 1'b0;
         chaining_allow      <= 1'b0;
         auto_enable         <= 1'b0;
         channel_priority    <= 2'h0;
      end else if (wr_ctrl) begin
         ignore_byte_value   <= reg_wdata[dcc_pkg::IGN_VAL_LSB +: 8];
         ignore_byte_enable  <= reg_wdata[dcc_pkg::IGN_EN_BIT];
         pattern_length_sel  <= reg_wdata[dcc_pkg::PAT_LEN_BIT];
         chain_direction_sel <= reg_wdata[dcc_pkg::CHAIN_DIR_BIT];
         events_while_off    <= reg_wdata[dcc_pkg::EVT_OFF_BIT];
         chaining_allow      <= reg_wdata[dcc_pkg::CHAIN_ALW_BIT];
         auto_enable         <= reg_wdata[dcc_pkg::AUTO_EN_BIT];
         channel_priority    <= reg_wdata[dcc_pkg::PRIO_LSB +: 2];
      end
   end

   // channel on: software write, chain completion, abort turns it off
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_on <= 1'b0;
      end else if (chain_hit) begin
         channel_on <= 1'b1;
      end else if (wr_ctrl) begin
         channel_on <= reg_wdata[dcc_pkg::CH_ON_BIT];
      end else if (abort_ok) begin
         channel_on <= 1'b0;
      end else if (block_now && !auto_enable) begin
         channel_on <= 1'b0;
      end
   end

   // busy: set by enable, held until the running transaction ends
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_active_flag <= 1'b0;
      end else if (channel_on || xfer_busy) begin
         channel_active_flag <= 1'b1;
      end else if (wr_ctrl) begin
         channel_active_flag <= reg_wdata[dcc_pkg::BUSY_BIT];
      end else begin
         channel_active_flag <= 1'b0;
      end
   end

   // event detected: set by an accepted start, dropped at block end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_detected <= 1'b0;
      end else if (start_ok) begin
         event_detected <= 1'b1;
      end else if (block_now || abort_ok) begin
         event_detected <= 1'b0;
      end
   end

   // start request to the engine, one cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_req <= 1'b0;
      end else begin
         start_req <= start_ok && channel_on;
      end
   end

   // ---------------------------------------------------------------
   // source size, pointer and pattern
   // ---------------------------------------------------------------
   // programmed source size
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_size <= 16'h0000;
      end else if (wr_size) begin
         src_size <= reg_wdata[dcc_pkg::SIZE_W-1:0];
      end
   end

   // pointer counts source beats and wraps at the end of source
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_pointer <= 16'h0000;
      end else if (wr_size || abort_ok) begin
         src_pointer <= 16'h0000;
      end else if (src_done_now) begin
         src_pointer <= 16'h0000;
      end else if (src_beat) begin
         src_pointer <= ptr_next;
      end
   end

   // termination pattern and pattern mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pattern      <= 16'h0000;
         pattern_mode <= 1'b0;
      end else if (wr_pat) begin
         pattern      <= reg_wdata[15:0];
         pattern_mode <= reg_wdata[dcc_pkg::PAT_MODE_BIT];
      end
   end

   // matcher hookup
   assign pif.byte_valid         = byte_valid && channel_on;
   assign pif.byte_data          = byte_data;
   assign pif.pattern            = pattern;
   assign pif.ignore_byte_value  = ignore_byte_value;
   assign pif.ignore_byte_enable = ignore_byte_enable;
   assign pif.pattern_length_sel = pattern_length_sel;
   assign pif.match_en           = pattern_mode;
   assign pattern_hit            = pif.hit;

   dcc_matcher u_matcher (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pi      (pif.mat)
   );

   // ---------------------------------------------------------------
   // interrupt enables and flags
   // ---------------------------------------------------------------
   // enables in bits 23:16 of the irq register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= 8'h00;
      end else if (wr_irq) begin
         irq_enable <= reg_wdata[dcc_pkg::IE_LSB +: 8];
      end
   end

   // one sticky flag per event; a hardware set beats any clear
   genvar gi;
   generate
      for (gi = 0; gi < dcc_pkg::NUM_EVT; gi++) begin : g_flag
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               irq_flag[gi] <= 1'b0;
            end else if (evt_set[gi]) begin
               irq_flag[gi] <= 1'b1;
            end else if (wr_irq) begin
               irq_flag[gi] <= reg_wdata[dcc_pkg::IF_LSB + gi];
            end else if (wr_clr && reg_wdata[gi]) begin
               irq_flag[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // level interrupt while any enabled flag is set
   assign irq = |(irq_flag & irq_enable);

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // control word, bits 23:16 and other holes read zero
   always_comb begin
      ctrl_word = dcc_pkg::RST_WORD;
      ctrl_word[dcc_pkg::IGN_VAL_LSB +: 8] = ignore_byte_value;
      ctrl_word[dcc_pkg::BUSY_BIT]      = channel_active_flag;
      ctrl_word[dcc_pkg::IGN_EN_BIT]    = ignore_byte_enable;
      ctrl_word[dcc_pkg::PAT_LEN_BIT]   = pattern_length_sel;
      ctrl_word[dcc_pkg::CHAIN_DIR_BIT] = chain_direction_sel;
      ctrl_word[dcc_pkg::CH_ON_BIT]     = channel_on;
      ctrl_word[dcc_pkg::EVT_OFF_BIT]   = events_while_off;
      ctrl_word[dcc_pkg::CHAIN_ALW_BIT] = chaining_allow;
      ctrl_word[dcc_pkg::AUTO_EN_BIT]   = auto_enable;
      ctrl_word[dcc_pkg::EVT_DET_BIT]   = event_detected;
      ctrl_word[dcc_pkg::PRIO_LSB +: 2] = channel_priority;
   end

   // irq word, bits 31:24 and 15:8 read zero
   always_comb begin
      irq_word = dcc_pkg::RST_WORD;
      irq_word[dcc_pkg::IE_LSB +: 8] = irq_enable;
      irq_word[dcc_pkg::IF_LSB +: 8] = irq_flag;
   end

   // address mux; unmapped and write-only offsets read zero
   always_comb begin
      case (reg_addr)
         dcc_pkg::OFS_CONTROL:  next_rdata = ctrl_word;
         dcc_pkg::OFS_IRQ_CTRL: next_rdata = irq_word;
         dcc_pkg::OFS_IRQ_STAT: next_rdata = {24'h00_0000, irq_flag};
         dcc_pkg::OFS_SRC_SIZE: next_rdata = {16'h0000, src_size};
         dcc_pkg::OFS_PATTERN:  next_rdata = {15'h0000, pattern_mode, pattern};
         dcc_pkg::OFS_SRC_PTR:  next_rdata = {16'h0000, src_pointer};
         default:               next_rdata = dcc_pkg::RST_WORD;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= dcc_pkg::RST_WORD;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= dcc_pkg::RST_WORD;
      end
   end

   // ---------------------------------------------------------------
   // engine side outputs
   // ---------------------------------------------------------------
   // new transactions only while on; a running one may finish
   assign channel_run          = channel_on;
   assign channel_priority_out = channel_priority;
endmodule

// ### hdl/dcc_pkg.sv
// Purpose: constants shared by the dma channel control and interrupt logic
// Assumes: one channel, 32-bit register port, byte stream for pattern matching
// Notes:   offsets are byte addresses, each register one aligned word
package dcc_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_IRQ_CTRL  = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h0C;
   localparam logic [7:0] OFS_SRC_SIZE  = 8'h10;
   localparam logic [7:0] OFS_PATTERN   = 8'h14;
   localparam logic [7:0] OFS_SRC_PTR   = 8'h18;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int IGN_VAL_LSB    = 24;
   localparam int BUSY_BIT       = 15;
   localparam int IGN_EN_BIT     = 13;
   localparam int PAT_LEN_BIT    = 11;
   localparam int CHAIN_DIR_BIT  = 8;
   localparam int CH_ON_BIT      = 7;
   localparam int EVT_OFF_BIT    = 6;
   localparam int CHAIN_ALW_BIT  = 5;
   localparam int AUTO_EN_BIT    = 4;
   localparam int EVT_DET_BIT    = 2;
   localparam int PRIO_LSB       = 0;

   // ---------------------------------------------------------------
   // interrupt register fields and event order
   // ---------------------------------------------------------------
   localparam int IE_LSB         = 16;
   localparam int IF_LSB         = 0;
   localparam int NUM_EVT        = 8;
   localparam int EVT_ADDR_ERR   = 0;
   localparam int EVT_ABORT      = 1;
   localparam int EVT_CELL       = 2;
   localparam int EVT_BLOCK      = 3;
   localparam int EVT_DST_HALF   = 4;
   localparam int EVT_DST_DONE   = 5;
   localparam int EVT_SRC_HALF   = 6;
   localparam int EVT_SRC_DONE   = 7;

   // ---------------------------------------------------------------
   // pattern register fields, widths, reset values
   // ---------------------------------------------------------------
   localparam int PAT_MODE_BIT   = 16;
   localparam int SIZE_W         = 16;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;
endpackage

// ### hdl/dcc_pat_if.sv
// Purpose: carries the byte stream and settings to the pattern matcher
// Assumes: all signals on ref_clk
// Notes:   hit is a one-cycle pulse
interface dcc_pat_if;
   logic        byte_valid;
   logic [7:0]  byte_data;
   logic [15:0] pattern;
   logic [7:0]  ignore_byte_value;
   logic        ignore_byte_enable;
   logic        pattern_length_sel;
   logic        match_en;
   logic        hit;

   modport ctl (output byte_valid, output byte_data, output pattern, output ignore_byte_value,
                output ignore_byte_enable, output pattern_length_sel, output match_en, input hit);
   modport mat (input byte_valid, input byte_data, input pattern, input ignore_byte_value,
                input ignore_byte_enable, input pattern_length_sel, input match_en, output hit);
endinterface

// ### hdl/dcc_matcher.sv
// Purpose: pattern-terminate matcher with optional ignore byte
// Assumes: one byte per cycle at most, bytes from same-clock logic
// Notes:   two-byte pattern is high byte first, then low byte
module dcc_matcher (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   dcc_pat_if.mat    pi
);
   logic [7:0] prev_byte;
   logic       prev_ok;
   logic       skip;
   logic       hit_now;

   // ignored bytes are don't-care: no history change, no hit
   assign skip = pi.ignore_byte_enable && (pi.byte_data == pi.ignore_byte_value);

   // one or two byte comparison
   always_comb begin
      hit_now = 1'b0;
      if (pi.match_en && pi.byte_valid && !skip) begin
         if (pi.pattern_length_sel) begin
            hit_now = prev_ok && (prev_byte == pi.pattern[15:8]) && (pi.byte_data == pi.pattern[7:0]);
         end else begin
            hit_now = (pi.byte_data == pi.pattern[7:0]);
         end
      end
   end

   // history of the last byte that counted
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_byte <= dcc_pkg::RST_BYTE;
         prev_ok   <= 1'b0;
      end else if (!pi.match_en) begin
         prev_ok   <= 1'b0;
      end else if (pi.byte_valid && !skip) begin
         prev_byte <= pi.byte_data;
         prev_ok   <= 1'b1;
      end
   end

   // registered hit pulse
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pi.hit <= 1'b0;
      end else begin
         pi.hit <= hit_now;
      end
   end
endmodule

// ### test/dcc_top_asserts.sv
// Purpose: port checks for the dma channel control block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound onto dcc_top at the foot of this file
module dcc_top_chk (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        start_evt,
   input wire logic        abort_evt,
   input wire logic        src_beat,
   input wire logic        dst_done_evt,
   input wire logic        dst_half_evt,
   input wire logic        cell_done_evt,
   input wire logic        block_done_evt,
   input wire logic        addr_err_evt,
   input wire logic        lower_done,
   input wire logic        higher_done,
   input wire logic        byte_valid,
   input wire logic        channel_run,
   input wire logic        start_req,
   input wire logic        pattern_hit,
   input wire logic [1:0]  channel_priority_out,
   input wire logic        irq
);
   // ---------------------------------------------
   // helpers and sequences
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   logic ctl_sel;
   logic quiet;
   logic any_set;
   // control select, competing updates, flag sources
   assign ctl_sel = reg_addr == dcc_pkg::OFS_CONTROL;
   assign quiet   = !(lower_done | higher_done | abort_evt | block_done_evt | pattern_hit);
   assign any_set = reg_wr | src_beat | dst_done_evt | dst_half_evt | cell_done_evt | block_done_evt
                    | addr_err_evt | abort_evt | pattern_hit;
   sequence s_ctl_rd;
      reg_rd && ctl_sel;
   endsequence
   sequence s_run_rd;
      channel_run[*2] ##0 reg_rd && ctl_sel;
   endsequence
   ctl_zero_a: assert property (s_ctl_rd |=> reg_rdata[23:16] == 8'h00)
      else $error("control bits 23 to 16 not zero");
   irq_zero_a: assert property (reg_rd && reg_addr == dcc_pkg::OFS_IRQ_CTRL |=>
      reg_rdata[31:24] == 8'h00 && reg_rdata[15:8] == 8'h00) else $error("irq reserved bits not zero");
   prio_copy_a: assert property (reg_wr && ctl_sel |=> channel_priority_out == $past(reg_wdata[1:0]))
      else $error("priority output differs from write");
   on_write_a: assert property (reg_wr && ctl_sel && quiet |=> channel_run == $past(reg_wdata[7]))
      else $error("channel run differs from written enable");
   run_hold_a: assert property (!channel_run && !lower_done && !higher_done && !reg_wr |=> !channel_run)
      else $error("channel started without write or chain");
   start_req_a: assert property (start_evt && channel_run |=> start_req)
      else $error("accepted start gave no request");
   abort_off_a: assert property (abort_evt && !lower_done && !higher_done && !reg_wr |=> !channel_run)
      else $error("abort left channel running");
   busy_run_a: assert property (s_run_rd |=> reg_rdata[15])
      else $error("busy reads 0 while channel on");
   hit_cause_a: assert property (pattern_hit |-> $past(byte_valid && channel_run))
      else $error("pattern hit without a counted byte");
   irq_rise_a: assert property ($rose(irq) |-> $past(any_set))
      else $error("irq rose with no event or write");
endmodule

bind dcc_top dcc_top_chk u_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .start_evt, .abort_evt, .src_beat, .dst_done_evt, .dst_half_evt, .cell_done_evt, .block_done_evt,
   .addr_err_evt, .lower_done, .higher_done, .byte_valid, .channel_run, .start_req, .pattern_hit,
   .channel_priority_out, .irq);

// ### test/dcc_bus_model.sv
// Purpose: bus side model, source beats and stream bytes
// Assumes: bench calls one task at a time
// Notes:   idle data line shows the inverse of the last byte
module dcc_bus_model (
   input  wire logic  ref_clk,
   output logic       xfer_busy,
   output logic       src_beat,
   output logic       byte_valid,
   output logic [7:0] byte_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      xfer_busy  = 1'b0;
      src_beat   = 1'b0;
      byte_valid = 1'b0;
      byte_data  = 8'h00;
   end
   // n source beats, transaction busy meanwhile
   task automatic beats(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         src_beat  <= 1'b1;
         xfer_busy <= 1'b1;
      end
      @(posedge ref_clk);
      src_beat  <= 1'b0;
      xfer_busy <= 1'b0;
   endtask
   // one stream byte, then scramble the data line
   task automatic send(input logic [7:0] b);
      @(posedge ref_clk);
      byte_valid <= 1'b1;
      byte_data  <= b;
      @(posedge ref_clk);
      byte_valid <= 1'b0;
      byte_data  <= ~b;
   endtask
endmodule

// ### test/testbench.sv
// Purpose: self-checking bench for the dma channel control block
// Assumes: bus model supplies beats and bytes
// Notes:   register tasks follow the one-cycle strobe protocol
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [8:0]  ev;
   logic [7:0]  byte_data;
   logic [1:0]  prio;
   logic        xfer_busy, src_beat, byte_valid, channel_run, start_req, pattern_hit, irq;
   int          n_mismatch, check_count, hits, cyc;
   logic [7:0]  amap [4] = '{dcc_pkg::OFS_CONTROL, dcc_pkg::OFS_IRQ_CTRL, dcc_pkg::OFS_IRQ_CLR, 8'h1C};
   int          fb [5] = '{5, 4, 2, 3, 0};
   int          ct [6][3] = '{'{32'h0000_0120, 8, 0}, '{32'h0000_0120, 7, 1}, '{32'h0000_0020, 7, 0},
                              '{32'h0000_0020, 8, 1}, '{32'h0000_0100, 7, 0}, '{32'h0000_0100, 8, 0}};
   logic [31:0] pt [3] = '{32'h3300_2880, 32'h3300_0880, 32'h3300_0080};
   int          hx [3] = '{1, 1, 2};
   // ---------------------------------------------
   // clock, watchdog, design and bus model
   // ---------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // hit counter and cycle ceiling
   always @(posedge ref_clk) begin
      cyc++;
      if (pattern_hit === 1'b1) hits++;
      if (cyc == 3000) begin
         n_mismatch++;
         conclude();
      end
   end
   dcc_top dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .start_evt(ev[0]), .abort_evt(ev[1]), .dst_done_evt(ev[2]), .dst_half_evt(ev[3]),
      .cell_done_evt(ev[4]), .block_done_evt(ev[5]), .addr_err_evt(ev[6]), .lower_done(ev[7]),
      .higher_done(ev[8]), .xfer_busy, .src_beat, .byte_valid, .byte_data, .channel_run,
      .start_req, .pattern_hit, .channel_priority_out(prio), .irq);
   dcc_bus_model partner (.ref_clk, .xfer_busy, .src_beat, .byte_valid, .byte_data);
   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one write cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   // one read cycle, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 chk($sformatf("reg %h", a), reg_rdata, exp);
   endtask
   // one-cycle event pulse
   task automatic pulse(input int i);
      @(posedge ref_clk);
      ev <= 9'h001 << i;
      @(posedge ref_clk);
      ev <= 9'h000;
      #1;
   endtask
   // counts and verdict
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // main sequence
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (amap[i]) rd(amap[i], 32'h0000_0000);
      $display("reset values done");
      wr(dcc_pkg::OFS_CONTROL, 32'hFFFF_FFFF);
      rd(dcc_pkg::OFS_CONTROL, 32'hFF00_A9F3);
      chk("priority", 32'(prio), 32'h0000_0003);
      fork
         partner.beats(8);
         begin
            wr(dcc_pkg::OFS_CONTROL, 32'h0000_0000);
            rd(dcc_pkg::OFS_CONTROL, 32'h0000_8000);
         end
      join
      rd(dcc_pkg::OFS_CONTROL, 32'h0000_0000);
      $display("control and busy done");
      wr(dcc_pkg::OFS_IRQ_CTRL, 32'hFFFF_FFFF);
      rd(dcc_pkg::OFS_IRQ_CTRL, 32'h00FF_00FF);
      chk("irq", 32'(irq), 32'h0000_0001);
      wr(dcc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_00FF);
      wr(dcc_pkg::OFS_IRQ_CLR, 32'h0000_00FF);
      rd(dcc_pkg::OFS_IRQ_CTRL, 32'h00FF_0000);
      chk("irq", 32'(irq), 32'h0000_0000);
      $display("interrupt register done");
      wr(dcc_pkg::OFS_IRQ_CTRL, 32'h0080_0000);
      wr(dcc_pkg::OFS_SRC_SIZE, 32'h0000_0004);
      wr(dcc_pkg::OFS_CONTROL, 32'h0000_0080);
      partner.beats(2);
      rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_0040);
      chk("irq", 32'(irq), 32'h0000_0000);
      partner.beats(2);
      rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_00C0);
      chk("irq", 32'(irq), 32'h0000_0001);
      rd(dcc_pkg::OFS_SRC_PTR, 32'h0000_0000);
      wr(dcc_pkg::OFS_IRQ_CTRL, 32'h0000_0000);
      foreach (fb[i]) begin
         pulse(i + 2);
         rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_0001 << fb[i]);
         wr(dcc_pkg::OFS_IRQ_CLR, 32'h0000_00FF);
      end
      $display("event flags done");
      wr(dcc_pkg::OFS_CONTROL, 32'h0000_0000);
      pulse(1);
      rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      wr(dcc_pkg::OFS_CONTROL, 32'h0000_0040);
      pulse(1);
      rd(dcc_pkg::OFS_IRQ_STAT, 32'h0000_0002);
      wr(dcc_pkg::OFS_CONTROL, 32'h0000_0080);
      pulse(0);
      chk("start request", 32'(start_req), 32'h0000_0001);
      rd(dcc_pkg::OFS_CONTROL, 32'h0000_8084);
      pulse(1);
      chk("channel run", 32'(channel_run), 32'h0000_0000);
      $display("start and abort done");
      wr(dcc_pkg::OFS_CONTROL, 32'h0000_0090);
      pulse(5);
      chk("auto run", 32'(channel_run), 32'h0000_0001);
      foreach (ct[i]) begin
         wr(dcc_pkg::OFS_CONTROL, ct[i][0]);
         pulse(ct[i][1]);
         chk("chained run", 32'(channel_run), ct[i][2]);
      end
      $display("chaining done");
      wr(dcc_pkg::OFS_PATTERN, 32'h0001_55AA);
      foreach (pt[i]) begin
         wr(dcc_pkg::OFS_CONTROL, pt[i]);
         partner.send(8'h55);
         partner.send(8'h33);
         partner.send(8'hAA);
         repeat (2) @(posedge ref_clk);
         chk("pattern hits", hits, hx[i]);
      end
      $display("pattern match done");
      conclude();
   end
endmodule
